// ==== verilog/sbci_top.sv ====
// Functional notes
// - Successful set commands get positive reply
// - Failed set commands get negative reply
// - Firmware chunks each acknowledged or rejected
// - Boot loader chunks each acknowledged or rejected individually
// - Read-config returns read-only configuration word
// - Config holds rate bits and selections
// - Config holds feature flag bits
// - Read-status returns status, calibration bit three
// - Status shows init failures and unresponsive sensors
// - Status shows flash and rate failures
// - Enter command mode; status mode bits
// - Streaming refuses all but enter-command
// - Fetch returns measurement per selection mask
// - Selection mask governs streamed and fetched
// - Stream rate accepts eight listed values
// - Format command selects float or integer
// - Timestamp load in 0.1 ms units
// - Arm hardware timestamp reset, then reply
`timescale 1ns/1ps
module sbci_top #(
  parameter int FIFO_DEPTH = 16,
  parameter int TS_DIV = sbci_pkg::TS_TICK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire sbci_pkg::sbci_req_t i_req,
  output logic o_rsp_valid,
  input wire logic i_rsp_ready,
  output sbci_pkg::sbci_rsp_t o_rsp,
  output logic o_chunk_valid,
  output logic [7:0] o_chunk_byte,
  output logic o_chunk_is_loader,
  input wire logic i_chunk_ok,
  input wire logic [31:0] i_meas_data,
  output logic [31:0] o_meas_sel,
  output logic o_stream_en,
  output logic [2:0] o_rate_code,
  output logic [31:0] o_timestamp,
  input wire logic i_ts_trigger,
  input wire logic i_gyro_cal,
  input wire logic [3:0] i_init_fail,
  input wire logic [2:0] i_unresp,
  input wire logic i_flash_fail,
  input wire logic i_dyn_mag,
  input wire logic i_gyro_thr,
  input wire logic i_mag_comp,
  input wire logic i_acc_comp,
  input wire logic i_gyro_auto
);
  localparam int QW = $bits(sbci_pkg::sbci_req_t);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  typedef enum logic [1:0] {
    SBCI_IDLE = 2'b00,
    SBCI_EXEC = 2'b01,
    SBCI_CHUNK = 2'b11,
    SBCI_REPLY = 2'b10
  } sbci_state_t;

  sbci_state_t st_q;
  sbci_pkg::sbci_req_t cur_q;
  logic [31:0] sel_q;
  logic [2:0] rate_q;
  logic fmt16_q;
  logic stream_q;
  logic rate_fail_q;
  logic ts_armed_q;
  logic [31:0] ts_q;
  logic [8:0] chunk_cnt_q;
  logic chunk_bad_q;
  logic [1:0] byte_idx_q;
  logic rsp_valid_q;
  sbci_pkg::sbci_rsp_t rsp_q;
  logic chunk_valid_q;
  logic [7:0] chunk_byte_q;
  logic chunk_ldr_q;
  logic [2:0] trig_sync_q;
  logic trig_lvl_q;

  // Request FIFO decouples the serial side from execution
  logic q_valid;
  sbci_pkg::sbci_req_t q_data;
  // Pop waits for the last reply to be taken, so o_rsp never changes under a pending reply
  wire q_pop = (st_q == SBCI_IDLE) && q_valid && !rsp_valid_q;
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  logic [CW-1:0] q_cnt_q;
  wire q_push = i_req_valid && o_req_ready;
  wire [CW-1:0] q_cnt_d = q_cnt_q + CW'(q_push) - CW'(q_pop);
  logic q_in_ready;
  sbci_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) i_sbci_fifo (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(q_push),
    .o_in_ready(q_in_ready),
    .i_in_data(i_req),
    .o_out_valid(q_valid),
    .i_out_ready(q_pop),
    .o_out_data(q_data)
  );
  logic ts_tick;
  sbci_tick #(.DIV(TS_DIV)) i_sbci_tick (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .o_tick(ts_tick)
  );

  // Rate value decoding; illegal rates flag failure
  wire [31:0] arg = cur_q.data;
  logic [2:0] rate_enc;
  logic rate_ok;
  always_comb begin
    rate_ok = 1'b1;
    unique case (arg)
      32'd5: rate_enc = 3'd0;
      32'd10: rate_enc = 3'd1;
      32'd30: rate_enc = 3'd2;
      32'd50: rate_enc = 3'd3;
      32'd100: rate_enc = 3'd4;
      32'd200: rate_enc = 3'd5;
      32'd300: rate_enc = 3'd6;
      32'd500: rate_enc = 3'd7;
      default: begin
        rate_enc = rate_q;
        rate_ok = 1'b0;
      end
    endcase
  end

  // Assembled configuration and status words
  wire [31:0] cfg_word = (32'(rate_q) << sbci_pkg::CFG_RATE_LSB)
                       | (sel_q & sbci_pkg::CFG_SEL_MASK)
                       | (32'(i_dyn_mag) << sbci_pkg::CFG_DMAG_BIT)
                       | (32'(fmt16_q) << sbci_pkg::CFG_FMT16_BIT)
                       | (32'(i_gyro_thr) << sbci_pkg::CFG_GTHR_BIT)
                       | (32'(i_mag_comp) << sbci_pkg::CFG_MCOMP_BIT)
                       | (32'(i_acc_comp) << sbci_pkg::CFG_ACOMP_BIT)
                       | (32'(i_gyro_auto) << sbci_pkg::CFG_GAUTO_BIT);
  wire [31:0] st_word = (32'(!stream_q) << sbci_pkg::ST_CMD_BIT)
                      | (32'(stream_q) << sbci_pkg::ST_STREAM_BIT)
                      | (32'(i_gyro_cal) << sbci_pkg::ST_GCAL_BIT)
                      | (32'(i_init_fail) << sbci_pkg::ST_INIT_LSB)
                      | (32'(i_unresp) << sbci_pkg::ST_UNRESP_LSB)
                      | (32'(i_flash_fail) << sbci_pkg::ST_FLASH_BIT)
                      | (32'(rate_fail_q) << sbci_pkg::ST_RATE_FAIL_BIT);

  // Streaming blocks everything except enter-command
  wire refused = stream_q && (cur_q.cmd != sbci_pkg::CMD_ENTER_CMD);
  wire is_chunk = (cur_q.cmd == sbci_pkg::CMD_FW_UPGRADE) || (cur_q.cmd == sbci_pkg::CMD_BL_UPGRADE);
  wire rsp_take = rsp_valid_q && i_rsp_ready;
  wire chunk_done = (chunk_cnt_q == 9'(sbci_pkg::CHUNK_BYTES - 1));

  // Trigger pin: three flops, change counted when stages two and three agree
  wire trig_agree = (trig_sync_q[1] == trig_sync_q[2]);
  wire trig_rise = trig_agree && trig_sync_q[2] && !trig_lvl_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      trig_sync_q <= '0;
      trig_lvl_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], i_ts_trigger};
      if (trig_agree) trig_lvl_q <= trig_sync_q[2];
    end
  end

  // Timestamp counter: load, armed pin reset, 0.1 ms tick
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ts_q <= '0;
      ts_armed_q <= 1'b0;
    end else if (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_TS_LOAD) begin
      ts_q <= arg;
    end else if (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_TS_ARM) begin
      ts_armed_q <= 1'b1;
    end else if (ts_armed_q && trig_rise) begin
      ts_q <= '0;
      ts_armed_q <= 1'b0;
    end else if (ts_tick) begin
      ts_q <= ts_q + 32'h0000_0001;
    end
  end

  // Command sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_q <= SBCI_IDLE;
      cur_q <= '0;
      sel_q <= '0;
      rate_q <= sbci_pkg::RATE_CODE_RESET;
      fmt16_q <= 1'b0;
      stream_q <= 1'b0;
      rate_fail_q <= 1'b0;
      chunk_cnt_q <= '0;
      chunk_bad_q <= 1'b0;
      byte_idx_q <= '0;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      chunk_valid_q <= 1'b0;
      chunk_byte_q <= '0;
      chunk_ldr_q <= 1'b0;
    end else begin
      chunk_valid_q <= 1'b0;
      if (rsp_take) rsp_valid_q <= 1'b0;
      unique case (st_q)
        SBCI_IDLE: if (q_pop) begin
          cur_q <= q_data;
          st_q <= SBCI_EXEC;
        end
        SBCI_EXEC: begin
          st_q <= SBCI_REPLY;
          rsp_q <= '{cmd: sbci_pkg::CMD_ACK, data: '0, has_data: 1'b0};
          if (refused) begin
            rsp_q.cmd <= sbci_pkg::CMD_NACK;
          end else begin
            unique case (cur_q.cmd)
              sbci_pkg::CMD_FW_UPGRADE, sbci_pkg::CMD_BL_UPGRADE: begin
                // Chunk bytes arrive four per request word, low byte first
                chunk_valid_q <= 1'b1;
                chunk_byte_q <= arg[7:0];
                chunk_ldr_q <= (cur_q.cmd == sbci_pkg::CMD_BL_UPGRADE);
                chunk_bad_q <= chunk_bad_q | !i_chunk_ok;
                byte_idx_q <= 2'd1;
                st_q <= SBCI_CHUNK;
              end
              sbci_pkg::CMD_READ_CFG: rsp_q <= '{cmd: cur_q.cmd, data: cfg_word, has_data: 1'b1};
              sbci_pkg::CMD_READ_STATUS: rsp_q <= '{cmd: cur_q.cmd, data: st_word, has_data: 1'b1};
              sbci_pkg::CMD_ENTER_CMD: stream_q <= 1'b0;
              sbci_pkg::CMD_ENTER_STREAM: stream_q <= 1'b1;
              sbci_pkg::CMD_FETCH_MEAS: rsp_q <= '{cmd: cur_q.cmd, data: i_meas_data & sel_q, has_data: 1'b1};
              sbci_pkg::CMD_OUT_SELECT: sel_q <= arg & sbci_pkg::CFG_SEL_MASK;
              sbci_pkg::CMD_STREAM_RATE: begin
                rate_q <= rate_enc;
                rate_fail_q <= !rate_ok;
                if (!rate_ok) rsp_q.cmd <= sbci_pkg::CMD_NACK;
              end
              sbci_pkg::CMD_OUT_FORMAT: begin
                if (arg > 32'h0000_0001) rsp_q.cmd <= sbci_pkg::CMD_NACK;
                else fmt16_q <= arg[0];
              end
              sbci_pkg::CMD_TS_LOAD, sbci_pkg::CMD_TS_ARM: ;
              default: rsp_q.cmd <= sbci_pkg::CMD_NACK;
            endcase
          end
        end
        SBCI_CHUNK: begin
          // Remaining bytes of the request word, then decide on chunk end
          if (byte_idx_q != 2'd0) begin
            chunk_valid_q <= 1'b1;
            chunk_byte_q <= arg[8*byte_idx_q +: 8];
            chunk_bad_q <= chunk_bad_q | !i_chunk_ok;
            chunk_cnt_q <= chunk_cnt_q + 9'd1;
            byte_idx_q <= byte_idx_q + 2'd1;
          end else if (chunk_done || cur_q.last) begin
            rsp_q <= '{cmd: (chunk_bad_q || !chunk_done) ? sbci_pkg::CMD_NACK : sbci_pkg::CMD_ACK,
                       data: '0, has_data: 1'b0};
            chunk_cnt_q <= '0;
            chunk_bad_q <= 1'b0;
            rsp_valid_q <= 1'b1;
            st_q <= SBCI_IDLE;
          end else begin
            chunk_cnt_q <= chunk_cnt_q + 9'd1;
            st_q <= SBCI_IDLE;
          end
        end
        SBCI_REPLY: if (!rsp_valid_q || rsp_take) begin
          rsp_valid_q <= 1'b1;
          st_q <= SBCI_IDLE;
        end
        default: st_q <= SBCI_IDLE;
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_req_ready <= 1'b0;
      q_cnt_q <= '0;
    end else begin
      o_req_ready <= (q_cnt_d < CW'(FIFO_DEPTH)); // Ready one edge ahead of the fill level
      q_cnt_q <= q_cnt_d;
    end
  end
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp = rsp_q;
  assign o_chunk_valid = chunk_valid_q;
  assign o_chunk_byte = chunk_byte_q;
  assign o_chunk_is_loader = chunk_ldr_q;
  assign o_meas_sel = sel_q;
  assign o_stream_en = stream_q;
  assign o_rate_code = rate_q;
  assign o_timestamp = ts_q;

  // Checks
  a_stream_refuse: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && stream_q && cur_q.cmd != sbci_pkg::CMD_ENTER_CMD) |=> rsp_q.cmd == sbci_pkg::CMD_NACK)
    else $error("command accepted in streaming mode");
  a_mode_bits: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_ENTER_STREAM) |=> st_word[1:0] == 2'b10)
    else $error("mode bits wrong");
  a_push_room: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    q_push |-> q_in_ready) else $error("push into full buffer");
  a_rate_bad: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_STREAM_RATE && !rate_ok)
    |=> rsp_q.cmd == sbci_pkg::CMD_NACK && rate_fail_q && $stable(rate_q)) else $error("bad rate accepted");
  a_cfg_read: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_READ_CFG)
    |=> rsp_q.data[2:0] == rate_q && rsp_q.data[8:3] == 6'h00) else $error("config word wrong");
  a_sel_mask: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (sel_q & ~sbci_pkg::CFG_SEL_MASK) == 32'h0000_0000) else $error("selection outside mask");
  a_fmt_bit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_OUT_FORMAT && arg == 32'h0000_0001)
    |=> fmt16_q && cfg_word[22]) else $error("format not applied");
  a_unknown_nack: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && cur_q.cmd == 8'h08) |=> rsp_q.cmd == sbci_pkg::CMD_NACK) else $error("unknown acked");
  a_reply_follows: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && !is_chunk && !rsp_valid_q) |=> ##1 rsp_valid_q) else $error("reply missing");
  a_ts_load: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    (st_q == SBCI_EXEC && !refused && cur_q.cmd == sbci_pkg::CMD_TS_LOAD) |=> ts_q == $past(arg))
    else $error("timestamp not loaded");
endmodule : sbci_top

// ==== verilog/sbci_pkg.sv ====
package sbci_pkg;
  // Command identifiers
  localparam logic [7:0] CMD_ACK = 8'h00;
  localparam logic [7:0] CMD_NACK = 8'h01;
  localparam logic [7:0] CMD_FW_UPGRADE = 8'h02;
  localparam logic [7:0] CMD_BL_UPGRADE = 8'h03;
  localparam logic [7:0] CMD_READ_CFG = 8'h04;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_ENTER_CMD = 8'h06;
  localparam logic [7:0] CMD_ENTER_STREAM = 8'h07;
  localparam logic [7:0] CMD_FETCH_MEAS = 8'h09;
  localparam logic [7:0] CMD_OUT_SELECT = 8'h0a;
  localparam logic [7:0] CMD_STREAM_RATE = 8'h0b;
  localparam logic [7:0] CMD_TS_LOAD = 8'h42;
  localparam logic [7:0] CMD_OUT_FORMAT = 8'h4b;
  localparam logic [7:0] CMD_TS_ARM = 8'h53;

  // Chunk size for uploads
  localparam int CHUNK_BYTES = 256;

  // Configuration word layout
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_RATE_W = 3;
  localparam int CFG_SEL_LSB = 9;
  localparam int CFG_SEL_W = 13;
  localparam logic [31:0] CFG_SEL_MASK = 32'h003f_7e00;
  localparam int CFG_DMAG_BIT = 20;
  localparam int CFG_FMT16_BIT = 22;
  localparam int CFG_GTHR_BIT = 23;
  localparam int CFG_MCOMP_BIT = 24;
  localparam int CFG_ACOMP_BIT = 25;
  localparam int CFG_GAUTO_BIT = 30;

  // Status word layout
  localparam int ST_CMD_BIT = 0;
  localparam int ST_STREAM_BIT = 1;
  localparam int ST_GCAL_BIT = 3;
  localparam int ST_INIT_LSB = 5;
  localparam int ST_UNRESP_LSB = 9;
  localparam int ST_FLASH_BIT = 12;
  localparam int ST_RATE_FAIL_BIT = 14;

  // Rate codes, index into table
  localparam logic [2:0] RATE_CODE_RESET = 3'h4;

  // Timestamp tick 0.1 ms
  localparam int TS_TICK_NS = 100000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int TS_TICK_CYC = TS_TICK_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] cmd;
    logic [31:0] data;
    logic last;
  } sbci_req_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [31:0] data;
    logic has_data;
  } sbci_rsp_t;
endpackage : sbci_pkg

// ==== verilog/sbci_fifo.sv ====
`timescale 1ns/1ps
module sbci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire empty = (wr_q == rd_q);
  wire full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  wire push = i_in_valid && !full;
  wire pop = !empty && i_out_ready;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_q[rd_q[AW-1:0]];

  // Pointers carry an extra wrap bit so full and empty are exact
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage has no reset
  always_ff @(posedge i_clk_sys) begin
    if (push) mem_q[wr_q[AW-1:0]] <= i_in_data;
  end
endmodule : sbci_fifo

// ==== verilog/sbci_tick.sv ====
`timescale 1ns/1ps
module sbci_tick #(
  parameter int DIV = 2000
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  output logic o_tick
);
  initial begin
    if (DIV < 1) $error("DIV must be at least 1");
  end
  logic [$clog2(DIV+1)-1:0] cnt_q;

  // One-cycle enable every DIV cycles
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || o_tick) cnt_q <= '0;
    else cnt_q <= cnt_q + 1'b1;
  end
  assign o_tick = (cnt_q == ($clog2(DIV+1))'(DIV - 1));
endmodule : sbci_tick

// ==== bench/sbci_host.sv ====
`timescale 1ns/1ps
// Host side of the command link: sends words, takes replies
module sbci_host (
  input wire logic i_clk_sys,
  input wire logic i_req_ready,
  input wire logic i_rsp_valid,
  input wire sbci_pkg::sbci_rsp_t i_rsp,
  output logic o_req_valid,
  output sbci_pkg::sbci_req_t o_req,
  output logic o_rsp_ready
);
  logic [7:0] sent_q[$];

  initial begin
    o_req_valid = 1'b0;
    o_req = '0;
    o_rsp_ready = 1'b0;
  end

  // Held until taken or 60 cycles pass; released lines show the inverse, never stale data
  task automatic push(input logic [7:0] id, input logic [31:0] d, input logic last, output logic taken);
    int n;
    n = 0;
    @(negedge i_clk_sys);
    o_req_valid = 1'b1;
    o_req = '{cmd: id, data: d, last: last};
    while (i_req_ready !== 1'b1 && n < 60) begin
      @(negedge i_clk_sys);
      n++;
    end
    taken = i_req_ready;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    o_req_valid = 1'b0;
    o_req = ~o_req;
  endtask : push

  // Slow taker: reply must stand until accepted
  task automatic get_rsp(output sbci_pkg::sbci_rsp_t r);
    int n;
    n = 0;
    while (i_rsp_valid !== 1'b1 && n < 3000) begin
      @(negedge i_clk_sys);
      n++;
    end
    r = i_rsp;
    if (n >= 3000) begin
      r.cmd = 8'hff;
    end
    repeat (1 + $urandom_range(2)) @(negedge i_clk_sys);
    o_rsp_ready = 1'b1;
    @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    o_rsp_ready = 1'b0;
  endtask : get_rsp

  // Image piece, four bytes a word, low byte first, last on final word
  task automatic chunk(input logic [7:0] id, input int nw);
    logic [31:0] w;
    logic t;
    for (int i = 0; i < nw; i++) begin
      w = $urandom;
      for (int b = 0; b < 4; b++) sent_q.push_back(w[8*b +: 8]);
      push(id, w, i == nw - 1, t);
    end
  endtask : chunk
endmodule : sbci_host

// ==== bench/tb_sbci_top.sv ====
`timescale 1ns/1ps
module tb_sbci_top;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic i_req_valid, o_req_ready, o_rsp_valid, i_rsp_ready, o_chunk_valid, o_chunk_is_loader, i_chunk_ok;
  logic o_stream_en, i_ts_trigger, i_gyro_cal, i_flash_fail, i_dyn_mag, i_gyro_thr, i_mag_comp, i_acc_comp;
  logic i_gyro_auto, ldr, t, m_fmt, m_stream;
  logic [7:0] o_chunk_byte;
  logic [31:0] i_meas_data, o_meas_sel, o_timestamp, m_sel, v, t1;
  logic [2:0] o_rate_code, i_unresp, m_rate;
  logic [3:0] i_init_fail;
  logic [7:0] got_q[$];
  sbci_pkg::sbci_req_t i_req;
  sbci_pkg::sbci_rsp_t o_rsp, r;
  int n_fail = 0;
  int compares = 0;
  int n;
  int rates[8] = '{5, 10, 30, 50, 100, 200, 300, 500};

  always #25 i_clk_sys = ~i_clk_sys;

  // Short timestamp divider keeps the run brief
  sbci_top #(.TS_DIV(4)) i_sbci_top (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
    .i_req(i_req), .o_rsp_valid(o_rsp_valid), .i_rsp_ready(i_rsp_ready), .o_rsp(o_rsp),
    .o_chunk_valid(o_chunk_valid), .o_chunk_byte(o_chunk_byte), .o_chunk_is_loader(o_chunk_is_loader),
    .i_chunk_ok(i_chunk_ok), .i_meas_data(i_meas_data), .o_meas_sel(o_meas_sel), .o_stream_en(o_stream_en),
    .o_rate_code(o_rate_code), .o_timestamp(o_timestamp), .i_ts_trigger(i_ts_trigger), .i_gyro_cal(i_gyro_cal),
    .i_init_fail(i_init_fail), .i_unresp(i_unresp), .i_flash_fail(i_flash_fail), .i_dyn_mag(i_dyn_mag),
    .i_gyro_thr(i_gyro_thr), .i_mag_comp(i_mag_comp), .i_acc_comp(i_acc_comp), .i_gyro_auto(i_gyro_auto)
  );

  sbci_host i_sbci_host (
    .i_clk_sys(i_clk_sys), .i_req_ready(o_req_ready), .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp),
    .o_req_valid(i_req_valid), .o_req(i_req), .o_rsp_ready(i_rsp_ready)
  );

  // Collect every strobed upload byte
  always @(posedge i_clk_sys) begin
    if (!i_reset && o_chunk_valid === 1'b1) begin
      got_q.push_back(o_chunk_byte);
      ldr = o_chunk_is_loader;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic reply(input logic [7:0] id, input logic [31:0] d, input logic [7:0] ecmd);
    i_sbci_host.push(id, d, 1'b0, t);
    i_sbci_host.get_rsp(r);
    check(32'(r.cmd), 32'(ecmd));
  endtask : reply

  // Bit 20 is shared by a selection and a feature flag, so it is left out
  function automatic logic [31:0] cfg_exp();
    logic [31:0] c;
    c = m_sel & sbci_pkg::CFG_SEL_MASK & 32'hffef_ffff;
    c[2:0] = m_rate;
    c[22] = m_fmt;
    c[23] = i_gyro_thr;
    c[24] = i_mag_comp;
    c[25] = i_acc_comp;
    c[30] = i_gyro_auto;
    return c;
  endfunction : cfg_exp

  // Rate-failure bit is judged on its own
  function automatic logic [31:0] st_exp();
    return {17'h0, 2'h0, i_flash_fail, i_unresp, i_init_fail, 1'b0, i_gyro_cal, 1'b0, m_stream, ~m_stream};
  endfunction : st_exp

  task automatic upload(input logic [7:0] id, input logic ok, input int nw, input logic [7:0] ecmd);
    got_q.delete();
    i_sbci_host.sent_q.delete();
    i_chunk_ok = ok;
    i_sbci_host.chunk(id, nw);
    i_sbci_host.get_rsp(r);
    check(32'(r.cmd), 32'(ecmd));
    check(32'(got_q.size()), 32'(nw * 4));
    check(32'(ldr), 32'(id == 8'h03));
    foreach (got_q[k]) check(32'(got_q[k]), 32'(i_sbci_host.sent_q[k]));
  endtask : upload

  task automatic pulse_trigger();
    @(negedge i_clk_sys);
    i_ts_trigger = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    i_ts_trigger = 1'b0;
    repeat (8) @(negedge i_clk_sys);
  endtask : pulse_trigger

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // Whole run needs far fewer than 40000 cycles
  initial begin
    #2ms;
    n_fail++;
    wrap_up();
  end

  initial begin
    i_chunk_ok = 1'b1;
    i_meas_data = '0;
    i_ts_trigger = 1'b0;
    {i_gyro_cal, i_init_fail, i_unresp, i_flash_fail, i_dyn_mag, i_gyro_thr, i_mag_comp, i_acc_comp, i_gyro_auto} = '0;
    m_rate = 3'h4;
    m_sel = '0;
    m_fmt = 1'b0;
    m_stream = 1'b0;
    void'($urandom(32'h450f_eb4f));
    repeat (16) @(negedge i_clk_sys);
    i_reset = 1'b0;
    @(negedge i_clk_sys);
    check(32'({o_rate_code, o_stream_en, o_rsp_valid, o_req_ready}), 32'h0000_0021);
    // Every listed rate, then refused ones leave the setting alone
    for (int i = 0; i < 8; i++) begin
      reply(8'h0b, rates[i], 8'h00);
      check(32'(o_rate_code), 32'(i));
    end
    m_rate = 3'h7;
    reply(8'h0b, 32'h0000_0007, 8'h01);
    reply(8'h0b, 32'h0000_01f5, 8'h01);
    check(32'(o_rate_code), 32'h0000_0007);
    reply(8'h05, 32'h0, 8'h05);
    check(32'(r.data[14]), 32'h0000_0001);
    reply(8'h4b, 32'h0000_0002, 8'h01);
    foreach (rates[i]) if (i < 3) reply(8'(8'h08 + 8'(i * 45)), 32'h0, 8'h01);
    // Random settings and status inputs, read back through both words
    repeat (4) begin
      {i_gyro_cal, i_init_fail, i_unresp, i_flash_fail, i_dyn_mag, i_gyro_thr, i_mag_comp, i_acc_comp, i_gyro_auto} = 14'($urandom);
      n = $urandom_range(7);
      m_rate = 3'(n);
      reply(8'h0b, rates[n], 8'h00);
      m_fmt = 1'($urandom_range(1));
      reply(8'h4b, 32'(m_fmt), 8'h00);
      m_sel = $urandom & sbci_pkg::CFG_SEL_MASK;
      reply(8'h0a, m_sel, 8'h00);
      check(o_meas_sel, m_sel);
      i_meas_data = $urandom;
      reply(8'h09, 32'h0, 8'h09);
      check(r.data, i_meas_data & m_sel);
      reply(8'h04, 32'h0, 8'h04);
      check(r.data & 32'hffef_ffff, cfg_exp());
      check(32'(r.data[20]), 32'(m_sel[20] | i_dyn_mag));
      reply(8'h05, 32'h0, 8'h05);
      check(r.data & 32'hffff_bfff, st_exp());
    end
    // Streaming refuses all but the return to command mode
    reply(8'h07, 32'h0, 8'h00);
    check(32'(o_stream_en), 32'h0000_0001);
    reply(8'h05, 32'h0, 8'h01);
    reply(8'h0a, 32'h0000_0200, 8'h01);
    check(o_meas_sel, m_sel);
    reply(8'h06, 32'h0, 8'h00);
    check(32'(o_stream_en), 32'h0);
    reply(8'h05, 32'h0, 8'h05);
    check(32'(r.data[1:0]), 32'h0000_0001);
    // Uploads: good, rejected by the store, and cut short
    upload(8'h02, 1'b1, 64, 8'h00);
    upload(8'h02, 1'b1, 64, 8'h00);
    upload(8'h03, 1'b0, 64, 8'h01);
    upload(8'h03, 1'b1, 64, 8'h00);
    upload(8'h02, 1'b1, 20, 8'h01);
    // Timestamp load, count rate, unarmed and armed trigger
    v = $urandom | 32'h0001_0000;
    reply(8'h42, v, 8'h00);
    t1 = o_timestamp;
    check(32'(t1 - v < 32'd16), 32'h0000_0001);
    repeat (40) @(negedge i_clk_sys);
    check(o_timestamp - t1, 32'h0000_000a);
    pulse_trigger();
    check(32'(o_timestamp < v), 32'h0);
    reply(8'h53, 32'h0, 8'h00);
    pulse_trigger();
    check(32'(o_timestamp < 32'd8), 32'h0000_0001);
    // Stall replies until the request buffer refuses, then drain it
    n = 0;
    t = 1'b1;
    while (t && n < 40) begin
      i_sbci_host.push(8'h04, 32'h0, 1'b0, t);
      if (t) n++;
    end
    check(32'(n >= 16 && n <= 20), 32'h0000_0001);
    check(32'(o_req_ready), 32'h0);
    repeat (n) begin
      i_sbci_host.get_rsp(r);
      check(32'(r.cmd), 32'h0000_0004);
    end
    repeat (6) @(negedge i_clk_sys);
    check(32'({o_rsp_valid, o_req_ready}), 32'h0000_0001);
    wrap_up();
  end
endmodule : tb_sbci_top
